// *** adc_ctrl_defs.vh ***
// Purpose: register offsets, fields, resets and timing for the converter control block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

`define TRACK_CTRL_ADDR   8'hb9
`define RESULT_HIGH_ADDR  8'hbe
`define POWER_CTRL_ADDR   8'hdf

`define TRACK_CTRL_RESET  8'h1e
`define RESULT_HIGH_RESET 8'h00
`define POWER_CTRL_RESET  8'h0f

`define BIAS_MSB          7
`define BIAS_LSB          6
`define MUX_LP_BIT        5
`define BUF_LP_BIT        4
`define PWRUP_MSB         3
`define PWRUP_LSB         0
`define SAMPLE_MODE_BIT   7
`define TRACK_MSB         5
`define TRACK_LSB         0
`define TRACK_CTRL_MASK   8'hbf

`define PWRUP_MULT        10'h008
`define TRACK_BASE        10'h040
`define EXTRA_SAR_TICKS   3'h4
`define SJ_LEFT           3'h4

`endif

// *** cycle_delay_timer.v ***
// Purpose: down counter that times the power-up and track delays
// Assumes: clk_in is the high-frequency oscillator clock
// Notes:   zero_out is high whenever the count has run out
`timescale 1ns/100ps
`default_nettype none
module cycle_delay_timer #(
    parameter WIDTH = 10
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             sys_rst_in,
    input  wire             ce_in,
    // control
    input  wire             load_in,
    input  wire [WIDTH-1:0] value_in,
    // status
    output wire             zero_out
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            if (load_in) begin
                count_reg <= value_in;
            end else if (count_reg != {WIDTH{1'b0}}) begin
                count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    assign zero_out = (count_reg == {WIDTH{1'b0}});
endmodule // cycle_delay_timer
`default_nettype wire

// *** adc_burst_ctrl.v ***
// Purpose: power/bias control, burst timing sequencer and result high byte of the converter
// Assumes: clk_in is the high-frequency oscillator; SAR ticks and core strobes share it
// Notes:   registers are reached over the SFR port at their own addresses
// How it works
// - bias_power_select bits 7:6 pick one of four bias current modes.
// - bit 5 puts mux and reference buffers into low power.
// - bit 4 lowers common-mode buffer power, needing longer tracking.
// - burst power-up delay is eight times bits 3:0, in oscillator cycles.
// - delayed-track adds four SAR clocks to power-up and track delays.
// - track delay between burst conversions is 64 minus bits 5:0.
// - no track delay before the first conversion of a burst.
// - sample mode bit 7 chooses four samples or one per 12-bit conversion.
// - reading result high byte gives accumulator MSB after shift and justify.
// - writing result high byte loads the accumulator upper byte.
// - right shifts fill vacated top bits of the read value with zeros.
// - delayed-track starts conversion four SAR clocks after start, tracking meanwhile.
// - shift-justify codes 0-3 right shift, 4 left justify, others reserved.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_burst_ctrl #(
    parameter DATA_WIDTH = 12
) (
    // clock and reset
    input  wire                  clk_in,
    input  wire                  sys_rst_in,
    input  wire                  ce_in,
    // special function register port
    input  wire [7:0]            sfr_addr_in,
    input  wire                  sfr_wr_in,
    input  wire                  sfr_rd_in,
    input  wire [7:0]            sfr_wdata_in,
    output reg  [7:0]            sfr_rdata_out,
    // settings held in neighbouring registers
    input  wire                  delayed_track_select_in,
    input  wire                  twelve_bit_mode_in,
    input  wire [2:0]            shift_justify_select_in,
    input  wire [2:0]            repeat_count_in,
    // burst control and converter core
    input  wire                  burst_start_in,
    input  wire                  sar_tick_in,
    input  wire                  conv_done_in,
    input  wire [DATA_WIDTH-1:0] conv_data_in,
    output reg                   conv_start_out,
    output reg                   tracking_out,
    output reg                   powered_up_out,
    output reg                   busy_out,
    // analog power settings
    output reg  [1:0]            bias_power_select_out,
    output reg                   mux_ref_low_power_out,
    output reg                   buffer_low_power_out,
    output reg                   sample_once_out
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_WAIT  = 5'h02;
    localparam [4:0] ST_EXTRA = 5'h04;
    localparam [4:0] ST_CONV  = 5'h08;
    localparam [4:0] ST_TRACK = 5'h10;

    reg  [7:0]  power_ctrl_reg;
    reg  [7:0]  track_ctrl_reg;
    reg  [15:0] accum_reg;
    reg  [4:0]  state_reg;
    reg  [2:0]  extra_reg;
    reg  [6:0]  conv_count_reg;
    reg         first_reg;
    reg         timer_load;
    reg  [9:0]  timer_value;
    reg  [15:0] formatted;
    reg  [6:0]  conv_total;
    wire        timer_zero;
    wire        wr_high;

    cycle_delay_timer #(.WIDTH(10)) delay_timer (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .load_in    (timer_load),
        .value_in   (timer_value),
        .zero_out   (timer_zero)
    );

    assign wr_high = sfr_wr_in && (sfr_addr_in == `RESULT_HIGH_ADDR);

    always @* begin
        formatted = accum_reg;
        if (shift_justify_select_in == `SJ_LEFT) begin
            formatted = twelve_bit_mode_in ? {accum_reg[11:0], 4'h0}
                                           : {accum_reg[9:0], 6'h00};
        end else if (!shift_justify_select_in[2]) begin
            formatted = accum_reg >> shift_justify_select_in[1:0];
        end
    end

    // conversions per burst; 12-bit mode runs a quarter as many unless the repeat count is zero
    always @* begin
        if (repeat_count_in == 3'h0) begin
            conv_total = 7'h01;
        end else begin
            conv_total = 7'h02 << repeat_count_in[2:0];
            if (repeat_count_in > 3'h5) begin
                conv_total = 7'h40;
            end
        end
        if (twelve_bit_mode_in && repeat_count_in != 3'h0) begin
            conv_total = conv_total >> 2;
        end
    end

    // sfr writes and reads
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            power_ctrl_reg <= `POWER_CTRL_RESET;
            track_ctrl_reg <= `TRACK_CTRL_RESET;
            sfr_rdata_out  <= 8'h00;
        end else if (ce_in) begin
            if (sfr_wr_in && sfr_addr_in == `POWER_CTRL_ADDR) begin
                power_ctrl_reg <= sfr_wdata_in;
            end
            // reserved bit kept at zero
            if (sfr_wr_in && sfr_addr_in == `TRACK_CTRL_ADDR) begin
                track_ctrl_reg <= sfr_wdata_in & `TRACK_CTRL_MASK;
            end
            if (sfr_rd_in) begin
                case (sfr_addr_in)
                    `POWER_CTRL_ADDR:  sfr_rdata_out <= power_ctrl_reg;
                    `TRACK_CTRL_ADDR:  sfr_rdata_out <= track_ctrl_reg;
                    `RESULT_HIGH_ADDR: sfr_rdata_out <= formatted[15:8];
                    default:           sfr_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            bias_power_select_out <= 2'h0;
            mux_ref_low_power_out <= 1'b0;
            buffer_low_power_out  <= 1'b0;
            sample_once_out       <= 1'b0;
        end else if (ce_in) begin
            bias_power_select_out <= power_ctrl_reg[`BIAS_MSB:`BIAS_LSB];
            mux_ref_low_power_out <= power_ctrl_reg[`MUX_LP_BIT];
            buffer_low_power_out  <= power_ctrl_reg[`BUF_LP_BIT];
            sample_once_out       <= track_ctrl_reg[`SAMPLE_MODE_BIT];
        end
    end

    always @* begin
        timer_load  = 1'b0;
        timer_value = 10'h000;
        case (state_reg)
            ST_IDLE: begin
                timer_load  = burst_start_in;
                timer_value = `PWRUP_MULT * {6'h00, power_ctrl_reg[`PWRUP_MSB:`PWRUP_LSB]};
            end
            ST_CONV: begin
                timer_load  = conv_done_in;
                timer_value = `TRACK_BASE - {4'h0, track_ctrl_reg[`TRACK_MSB:`TRACK_LSB]};
            end
            default: begin
                timer_load  = 1'b0;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg      <= ST_IDLE;
            extra_reg      <= 3'h0;
            conv_count_reg <= 7'h00;
            first_reg      <= 1'b0;
            conv_start_out <= 1'b0;
            tracking_out   <= 1'b0;
            powered_up_out <= 1'b0;
            busy_out       <= 1'b0;
        end else if (ce_in) begin
            conv_start_out <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (burst_start_in) begin
                        state_reg      <= ST_WAIT;
                        conv_count_reg <= 7'h00;
                        first_reg      <= 1'b1;
                        busy_out       <= 1'b1;
                        powered_up_out <= 1'b1;
                        tracking_out   <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (timer_zero) begin
                        extra_reg <= 3'h0;
                        // extra SAR clocks on both delays
                        if (delayed_track_select_in) begin
                            state_reg <= ST_EXTRA;
                        end else begin
                            state_reg      <= ST_CONV;
                            conv_start_out <= 1'b1;
                            tracking_out   <= 1'b0;
                        end
                    end
                end
                ST_EXTRA: begin
                    if (sar_tick_in) begin
                        extra_reg <= extra_reg + 3'h1;
                        if (extra_reg == `EXTRA_SAR_TICKS - 3'h1) begin
                            state_reg      <= ST_CONV;
                            conv_start_out <= 1'b1;
                            tracking_out   <= 1'b0;
                        end
                    end
                end
                ST_CONV: begin
                    if (conv_done_in) begin
                        first_reg      <= 1'b0;
                        conv_count_reg <= conv_count_reg + 7'h01;
                        if (conv_count_reg + 7'h01 >= conv_total) begin
                            state_reg      <= ST_IDLE;
                            busy_out       <= 1'b0;
                            powered_up_out <= 1'b0;
                        end else begin
                            state_reg    <= ST_WAIT;
                            tracking_out <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // accumulator: first result of a burst replaces, later ones add
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            accum_reg <= {`RESULT_HIGH_RESET, 8'h00};
        end else if (ce_in) begin
            if (wr_high) begin
                accum_reg[15:8] <= sfr_wdata_in;
            end else if (state_reg == ST_CONV && conv_done_in) begin
                accum_reg <= first_reg ? {{(16-DATA_WIDTH){1'b0}}, conv_data_in}
                                       : accum_reg + {{(16-DATA_WIDTH){1'b0}}, conv_data_in};
            end
        end
    end
endmodule // adc_burst_ctrl
`default_nettype wire

// *** adc_burst_ctrl_sva.sv ***
// Purpose: port-level checks on the burst converter control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_burst_ctrl_sva (
    // clock and reset
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       ce_in,
    // register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // burst and core
    input wire logic       burst_start_in,
    input wire logic       conv_done_in,
    input wire logic       conv_start_out,
    input wire logic       tracking_out,
    input wire logic       powered_up_out,
    input wire logic       busy_out,
    // power settings
    input wire logic [1:0] bias_power_select_out,
    input wire logic       mux_ref_low_power_out,
    input wire logic       buffer_low_power_out,
    input wire logic       sample_once_out
);
    logic [3:0] pwrup_field;
    // power-up field as last written, so a zero delay is not held to a wait
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            pwrup_field <= 4'(`POWER_CTRL_RESET);
        end else if (ce_in && sfr_wr_in && sfr_addr_in == `POWER_CTRL_ADDR) begin
            pwrup_field <= sfr_wdata_in[3:0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_taken;
        burst_start_in && !busy_out && ce_in;
    endsequence
    sequence s_armed;
        busy_out && tracking_out && !conv_start_out;
    endsequence
    chk_burst_arms: assert property (s_taken |=> s_armed)
        else $error("burst start not taken");
    chk_first_wait: assert property (($rose(busy_out) && pwrup_field != 4'h0) |-> !conv_start_out [*8])
        else $error("conversion started too early");
    chk_start_pulse: assert property (conv_start_out |=> !conv_start_out)
        else $error("conversion start longer than one cycle");
    chk_track_then_conv: assert property (conv_start_out |-> !tracking_out && $past(tracking_out))
        else $error("conversion start without tracking before it");
    chk_busy_power: assert property (busy_out == powered_up_out)
        else $error("busy and powered differ");
    chk_start_in_burst: assert property (conv_start_out |-> busy_out)
        else $error("conversion start outside a burst");
    chk_burst_end: assert property ($fell(busy_out) |-> $past(conv_done_in))
        else $error("burst ended without a result");
    chk_power_fields: assert property ((sfr_wr_in && sfr_addr_in == `POWER_CTRL_ADDR) |-> ##2
        ({bias_power_select_out, mux_ref_low_power_out, buffer_low_power_out}
        == $past(sfr_wdata_in[7:4], 2))) else $error("power outputs do not follow write");
    chk_sample_mode: assert property ((sfr_wr_in && sfr_addr_in == `TRACK_CTRL_ADDR) |-> ##2
        sample_once_out == $past(sfr_wdata_in[7], 2)) else $error("sample mode not applied");
    chk_rdata_holds: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data changed without a read");
endmodule // adc_burst_ctrl_sva
bind adc_burst_ctrl adc_burst_ctrl_sva adc_burst_ctrl_sva_i (.*);
`default_nettype wire

// *** sar_core_model.sv ***
// Purpose: behavioural converter core answering conversion starts
// Assumes: same clock as the control block
// Notes:   data moves every cycle so a stale sample never passes
`timescale 1ns/100ps
`default_nettype none
module sar_core_model #(
    parameter int CONV_CYC = 6
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // control
    input  wire logic        conv_start_in,
    input  wire logic        slow_in,
    // answers
    output logic             sar_tick_out,
    output logic             conv_done_out,
    output logic [11:0]      conv_data_out
);
    logic [3:0] cnt_reg;
    logic [1:0] div_reg;
    always @(posedge clk_in) begin
        div_reg <= sys_rst_in ? 2'h0 : div_reg + 2'h1;
        sar_tick_out <= div_reg == 2'h3;
        conv_data_out <= sys_rst_in ? 12'h3a7 : conv_data_out + 12'h9d5;
        conv_done_out <= !sys_rst_in && cnt_reg == 4'h1;
        if (sys_rst_in || conv_start_in) begin
            cnt_reg <= sys_rst_in ? 4'h0 : slow_in ? 4'hf : 4'(CONV_CYC);
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule // sar_core_model
`default_nettype wire

// *** adc_burst_ctrl_tb.sv ***
// Purpose: self-checking bench for the burst converter control block
// Assumes: core model answers every conversion start
// Notes:   random settings from a fixed seed, corner cases first
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.vh"
module adc_burst_ctrl_tb;
    logic        clk_in, sys_rst_in, ce_in, sfr_wr_in, sfr_rd_in, burst_start_in, slow, sm;
    logic        delayed_track_select_in, twelve_bit_mode_in;
    logic [2:0]  shift_justify_select_in, repeat_count_in, r;
    logic [7:0]  sfr_addr_in, sfr_wdata_in, v, m;
    logic [3:0]  pwr;
    logic [5:0]  tk;
    logic [15:0] acc_m;
    wire  [7:0]  sfr_rdata_out;
    wire  [11:0] conv_data_in;
    wire  [1:0]  bias_power_select_out;
    wire         sar_tick_in, conv_done_in, conv_start_out, tracking_out, powered_up_out;
    wire         busy_out, mux_ref_low_power_out, buffer_low_power_out, sample_once_out;
    int          n_fail, tests_run, cyc, nst, ndone, base;
    adc_burst_ctrl adc_burst_ctrl_i (.*);
    sar_core_model sar_core_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .conv_start_in(conv_start_out), .slow_in(slow), .sar_tick_out(sar_tick_in),
        .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {sfr_addr_in, sfr_wdata_in, sfr_wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        {sfr_addr_in, sfr_rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        @(negedge clk_in);
        chk("read data", e, sfr_rdata_out);
    endtask
    function automatic int nexp(input logic [2:0] c, input logic tw);
        int n;
        n = (c == 3'h0) ? 1 : (c > 3'h4) ? 64 : 2 << c;
        return (tw && c != 3'h0) ? n / 4 : n;
    endfunction
    function automatic logic [7:0] fmt(input logic [15:0] a, input logic [2:0] s, input logic tw);
        logic [15:0] q;
        q = (s < 3'h4) ? a >> s : (s == 3'h4) ? a << (tw ? 4 : 6) : a;
        return q[15:8];
    endfunction
    // second start lands while busy and must be ignored
    task automatic burst(input int n);
        @(posedge clk_in) burst_start_in <= 1'b1;
        @(posedge clk_in) burst_start_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        burst_start_in <= 1'b1;
        @(posedge clk_in) burst_start_in <= 1'b0;
        for (int k = 0; k < 3000 && busy_out; k++) @(posedge clk_in);
        @(negedge clk_in);
        chk("conversions", n, nst);
        chk("results", n, ndone);
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (burst_start_in && !busy_out && !sys_rst_in) begin
            {cyc, nst, ndone} <= {32'd1, 32'd0, 32'd0};
        end
        if (conv_start_out) begin
            base = (ndone == 0 ? 8 * pwr : 64 - tk) + 2;
            // delayed tracking waits on free-running ticks, so only a window is known
            if (delayed_track_select_in && cyc >= base + 13 && cyc <= base + 16) base = cyc;
            chk("conversion gap", base, cyc);
            nst <= nst + 1;
        end
        if (conv_done_in) begin
            cyc <= 1;
            ndone <= ndone + 1;
            acc_m <= (ndone == 0 ? 16'h0 : acc_m) + {4'h0, conv_data_in};
        end
    end
    initial begin
        repeat (60000) @(posedge clk_in);
        n_fail++;
        conclude();
    end
    initial begin
        {ce_in, sys_rst_in, sfr_wr_in, sfr_rd_in, burst_start_in, slow} = 6'b110000;
        {delayed_track_select_in, twelve_bit_mode_in, shift_justify_select_in} = 5'h0;
        {sfr_addr_in, sfr_wdata_in, repeat_count_in, pwr, tk, acc_m} = 45'h0;
        v = 8'($urandom(32'hf1f4));
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(`POWER_CTRL_ADDR, `POWER_CTRL_RESET);
        rd(`TRACK_CTRL_ADDR, `TRACK_CTRL_RESET);
        rd(`RESULT_HIGH_ADDR, `RESULT_HIGH_RESET);
        rd(8'h55, 8'h00);
        wr(`TRACK_CTRL_ADDR, 8'hff);
        rd(`TRACK_CTRL_ADDR, 8'hbf);
        for (int i = 0; i < 24; i++) begin
            pwr = (i == 0) ? 4'h0 : 4'($urandom_range(15, 0));
            tk = (i > 0 && i < 4) ? 6'h3f : 6'($urandom_range(63, 0));
            v = 8'($urandom);
            m = 8'($urandom);
            // long bursts only with the shortest track delay
            r = (i == 2) ? 3'h5 : (i == 3) ? 3'h7 : 3'($urandom_range(2, 0));
            sm = m[0] && nexp(r, m[0]) == 1;
            @(posedge clk_in);
            {twelve_bit_mode_in, slow, shift_justify_select_in} <= {m[0], m[2], m[5:3]};
            {repeat_count_in, delayed_track_select_in} <= {r, m[1] && i > 3};
            wr(`POWER_CTRL_ADDR, {v[7:4], pwr});
            repeat (2) @(negedge clk_in);
            chk("power outputs", v[7:4], {bias_power_select_out, mux_ref_low_power_out,
                buffer_low_power_out});
            wr(`TRACK_CTRL_ADDR, {sm, 1'b0, tk});
            rd(`TRACK_CTRL_ADDR, {sm, 1'b0, tk});
            chk("sample mode", sm, sample_once_out);
            burst(nexp(r, m[0]));
            rd(`RESULT_HIGH_ADDR, fmt(acc_m, m[5:3], m[0]));
            wr(`RESULT_HIGH_ADDR, v);
            acc_m[15:8] = v;
            rd(`RESULT_HIGH_ADDR, fmt(acc_m, m[5:3], m[0]));
        end
        conclude();
    end
endmodule // adc_burst_ctrl_tb
`default_nettype wire
